/* logic/tes_pkg.sv */
// Purpose: Shared constants for the count-edge qualification block.
// Assumes: One clock (ref_clk, 100 MHz), synchronous active-low reset.
// Notes:   Register offsets are byte addresses of 32-bit words.
package tes_pkg;

    // Register bus geometry
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 32;
    localparam logic [7:0]  OFF_CTRL       = 8'h00;
    localparam logic [7:0]  OFF_STATUS     = 8'h04;

    // Control register field positions
    localparam int          CTL_EDGE_LSB   = 0;   // count_edge_field [1:0]
    localparam int          CTL_SRC_LSB    = 2;   // count source [3:2]
    localparam int          CTL_PRE_LSB    = 4;   // prescale select [5:4]
    localparam int          CTL_LEGACY_BIT = 6;   // legacy encoding variant
    localparam int          CTL_PHASE_BIT  = 7;   // phase counting selected
    localparam int          CTL_W          = 8;
    localparam logic [7:0]  CTL_RESET      = 8'h00;

    // Status register field positions
    localparam int          STA_CNT_LSB    = 0;   // qualified event count
    localparam int          STA_CNT_W      = 16;
    localparam int          STA_EXT_BIT    = 16;  // synchronised pin level
    localparam int          STA_PSC_BIT    = 17;  // prescaled clock level
    localparam int          STA_OVR_BIT    = 18;  // phase override active

    // Edge field encodings
    localparam logic [1:0]  EDGE_00        = 2'h0;
    localparam logic [1:0]  EDGE_01        = 2'h1;

    // Prescaler
    localparam int          PSC_W          = 6;
    localparam logic [5:0]  PSC_RESET      = 6'h00;

    // Count source selection
    typedef enum logic [1:0] {
        SRC_INTERNAL  = 2'b00,
        SRC_EXTERNAL  = 2'b01,
        SRC_OVERFLOW  = 2'b10,
        SRC_UNDERFLOW = 2'b11
    } tes_src_t;

    // Prescale selection
    typedef enum logic [1:0] {
        PRE_DIV1  = 2'b00,
        PRE_DIV4  = 2'b01,
        PRE_DIV16 = 2'b10,
        PRE_DIV64 = 2'b11
    } tes_pre_t;

endpackage

/* logic/tes_edge_if.sv */
// Purpose: Carries one level and its detected edges between modules.
// Assumes: All signals live in the ref_clk domain.
// Notes:   rise and fall are one-cycle pulses.
interface tes_edge_if;
    logic level;
    logic rise;
    logic fall;

    // Detector side
    modport det (
        input  level,
        output rise,
        output fall
    );

    // Consumer side
    modport user (
        output level,
        input  rise,
        input  fall
    );
endinterface

/* logic/tes_edge_detect.sv */
// Purpose: Rising and falling edge detector on a same-domain level.
// Assumes: level is already in the ref_clk domain.
// Notes:   The first cycle after reset only loads history.
module tes_edge_detect
    import tes_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // Level in, edges out
    tes_edge_if.det   e
);

    logic hist_reg;
    logic primed_reg;

    // History and priming; priming blocks a false edge after reset
    // history cleared, first sample primes
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            hist_reg   <= 1'b0;
            primed_reg <= 1'b0;
        end else begin
            hist_reg   <= e.level;
            primed_reg <= 1'b1;
        end
    end

    assign e.rise = primed_reg & e.level & ~hist_reg;
    assign e.fall = primed_reg & ~e.level & hist_reg;

endmodule

/* logic/tes_count_edge_select.sv */
// Purpose: Count-edge qualification for one channel of a pulse timer.
// Assumes: ref_clk 100 MHz; nrst synchronous, active low; ext_clk_pin
//          is asynchronous; overflow and underflow are same-domain pulses.
// Notes:   count_en is a one-cycle pulse per qualified count event.
//
// Summary of operation
// - Internal, code 00: count falling edges
// - Internal, code 01: count rising edges
// - Internal, code 10/11: count both edges
// - External: 00 rise, 01 fall, 1x both
// - Both edges doubles rate of rising
// - Edge field only for divide-by-4 or slower
// - Overflow/underflow: ignore field, count each
// - Legacy: 00 rise, 01 fall, 1x both
// - Legacy phase mode on 1,2,4,5 overrides
//
// Added by the designer: the register addresses and the address-and-strobe port.
module tes_count_edge_select
    import tes_pkg::*;
#(
    parameter int CHANNEL = 1
)
(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // Count sources
    input  wire logic              ext_clk_pin,
    input  wire logic              other_ovf,
    input  wire logic              other_udf,
    // Qualified count output
    output logic                   count_en,
    output logic                   phase_override
);

    // Phase counting exists only on these channels
    localparam logic PHASE_CAPABLE = (CHANNEL == 1) || (CHANNEL == 2) ||
                                     (CHANNEL == 4) || (CHANNEL == 5);

    // Registers
    logic [CTL_W-1:0]     channel_control_reg;
    logic [PSC_W-1:0]     psc_reg;
    logic                 ext_meta_reg;
    logic                 ext_sync_reg;
    logic                 count_en_reg;
    logic                 ovr_reg;
    logic [STA_CNT_W-1:0] evt_cnt_reg;
    logic [STA_CNT_W-1:0] evt_cnt_next;
    logic [DATA_W-1:0]    rdata_reg;

    // Decoded control fields
    logic [1:0] count_edge_field;
    logic       count_edge_high_bit;
    logic       count_edge_low_bit;
    tes_src_t   src_sel;
    tes_pre_t   pre_sel;
    logic       legacy_mode;
    logic       phase_mode;

    assign count_edge_field    = channel_control_reg[CTL_EDGE_LSB +: 2];
    assign count_edge_high_bit = count_edge_field[1];
    assign count_edge_low_bit  = count_edge_field[0];
    assign src_sel     = tes_src_t'(channel_control_reg[CTL_SRC_LSB +: 2]);
    assign pre_sel     = tes_pre_t'(channel_control_reg[CTL_PRE_LSB +: 2]);
    assign legacy_mode = channel_control_reg[CTL_LEGACY_BIT];
    assign phase_mode  = channel_control_reg[CTL_PHASE_BIT];

    // Address decode
    logic sel_ctrl;
    logic sel_status;
    assign sel_ctrl   = (reg_addr == OFF_CTRL);
    assign sel_status = (reg_addr == OFF_STATUS);

    // Control register; only the low byte is stored
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            channel_control_reg <= CTL_RESET;
        end else if (reg_wr && sel_ctrl) begin
            channel_control_reg <= reg_wdata[CTL_W-1:0];
        end
    end

    // Free-running prescaler; each tap is a square wave
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            psc_reg <= PSC_RESET;
        end else begin
            psc_reg <= psc_reg + 6'h01;
        end
    end

    // Prescaled clock level picked by the prescale select.
    // square taps, both edges double rate
    // A tap of period N toggles every N/2 cycles, so counting both of its
    // edges gives the same rate as rising edges of the tap of period N/2.
    logic psc_level;
    always_comb begin
        case (pre_sel)
            PRE_DIV4:  psc_level = psc_reg[1];
            PRE_DIV16: psc_level = psc_reg[3];
            PRE_DIV64: psc_level = psc_reg[5];
            default:   psc_level = 1'b0;  // Undivided: every clock counts
        endcase
    end

    // Pin synchroniser; only the second stage is read by logic
    // sample pin in clock domain
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
        end else begin
            ext_meta_reg <= ext_clk_pin;
            ext_sync_reg <= ext_meta_reg;
        end
    end

    // Edge detectors: index 0 internal prescaled, index 1 external pin
    tes_edge_if eif[2] ();
    logic [1:0] src_level;
    logic [1:0] src_rise;
    logic [1:0] src_fall;
    assign src_level[0] = psc_level;
    assign src_level[1] = ext_sync_reg;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_det
            assign eif[gi].level = src_level[gi];
            assign src_rise[gi]  = eif[gi].rise;
            assign src_fall[gi]  = eif[gi].fall;
            tes_edge_detect u_det (
                .ref_clk (ref_clk),
                .nrst    (nrst),
                .e       (eif[gi])
            );
        end
    endgenerate

    // Edge selection decode; both encodings share the 1x code
    logic want_rise;
    logic want_fall;
    always_comb begin
        want_rise = 1'b0;
        want_fall = 1'b0;
        if (count_edge_high_bit) begin
            want_rise = 1'b1;
            want_fall = 1'b1;
        end else if (legacy_mode || (src_sel == SRC_EXTERNAL)) begin
            want_rise = (count_edge_field == EDGE_00);
            want_fall = count_edge_low_bit;
        end else begin
            want_fall = (count_edge_field == EDGE_00);
            want_rise = count_edge_low_bit;
        end
    end

    // Phase counting override in the legacy variant
    // phase mode takes priority
    logic phase_ovr;
    assign phase_ovr = legacy_mode & phase_mode & PHASE_CAPABLE;

    // Qualified count event, by source
    logic int_edge;
    logic ext_edge;
    logic qualified;
    assign int_edge = (want_rise & src_rise[0]) | (want_fall & src_fall[0]);
    assign ext_edge = (want_rise & src_rise[1]) | (want_fall & src_fall[1]);

    always_comb begin
        case (src_sel)
            SRC_INTERNAL: begin
                if (pre_sel == PRE_DIV1) begin
                    qualified = 1'b1;
                end else begin
                    qualified = int_edge;
                end
            end
            SRC_EXTERNAL:  qualified = ext_edge;
            SRC_OVERFLOW:  qualified = other_ovf;
            SRC_UNDERFLOW: qualified = other_udf;
            default:       qualified = 1'b0;
        endcase
        if (phase_ovr) begin
            // Phase decoding, outside this block, drives the counter
            qualified = 1'b0;
        end
    end

    // Registered count enable; one pulse per qualified event
    // single-cycle count enable
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            count_en_reg <= 1'b0;
            ovr_reg      <= 1'b0;
        end else begin
            count_en_reg <= qualified;
            ovr_reg      <= phase_ovr;
        end
    end

    assign count_en       = count_en_reg;
    assign phase_override = ovr_reg;

    // Event counter for software; a status write clears it, but a pulse
    // landing in the same cycle still counts, so none is lost
    always_comb begin
        evt_cnt_next = evt_cnt_reg;
        if (reg_wr && sel_status) begin
            evt_cnt_next = '0;
        end
        if (count_en_reg) begin
            evt_cnt_next = evt_cnt_next + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            evt_cnt_reg <= '0;
        end else begin
            evt_cnt_reg <= evt_cnt_next;
        end
    end

    // Read mux; unmapped addresses read zero
    logic [DATA_W-1:0] ctrl_word;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        ctrl_word   = '0;
        ctrl_word[CTL_W-1:0] = channel_control_reg;
        status_word = '0;
        status_word[STA_CNT_LSB +: STA_CNT_W] = evt_cnt_reg;
        status_word[STA_EXT_BIT] = ext_sync_reg;
        status_word[STA_PSC_BIT] = psc_level;
        status_word[STA_OVR_BIT] = ovr_reg;
        if (sel_ctrl) begin
            rd_mux = ctrl_word;
        end else if (sel_status) begin
            rd_mux = status_word;
        end else begin
            rd_mux = '0;
        end
    end

    // Read data stand one cycle after the strobe and read zero otherwise
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata_reg <= '0;
        end else if (reg_rd) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= '0;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule

/* testbench/tes_count_edge_select_sva.sv */
// Purpose: Port-level checks of count-edge qualification.
// Assumes: Control is shadowed from register writes seen at the ports.
// Notes:   Most checks wait for a settled setup, as changes may slip one.
module tes_count_edge_select_sva
    import tes_pkg::*;
#(
    parameter int CHANNEL = 1
)
(
    // Clock and reset
    input wire logic              ref_clk,
    input wire logic              nrst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Sources and outputs
    input wire logic              ext_clk_pin,
    input wire logic              other_ovf,
    input wire logic              other_udf,
    input wire logic              count_en,
    input wire logic              phase_override
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] ctl_reg;
    logic [6:0] age_reg;
    logic [6:0] gap_reg;
    logic [5:0] psc_m_reg;

    // Decoded shadow; per is the expected event spacing of a prescaler tap
    wire       old  = &age_reg;
    wire       cwr  = reg_wr && reg_addr == OFF_CTRL;
    wire       intl = ctl_reg[3:2] == SRC_INTERNAL;
    wire       extl = ctl_reg[3:2] == SRC_EXTERNAL;
    wire       cap  = CHANNEL inside {1, 2, 4, 5};
    wire       ovr  = ctl_reg[6] && ctl_reg[7] && cap;
    wire       d4   = ctl_reg[5:4] == PRE_DIV4;
    wire       d16  = ctl_reg[5:4] == PRE_DIV16;
    wire [6:0] per  = (d4 ? 7'h04 : d16 ? 7'h10 : 7'h40) >> ctl_reg[1];

    // Tap of a prescaler copy; a single-edge code leaves it at lvl, the
    // low code bit, inverted in the legacy variant
    wire       tap  = d4 ? psc_m_reg[1] : d16 ? psc_m_reg[3] : psc_m_reg[5];
    wire       lvl  = ctl_reg[0] ^ ctl_reg[6];

    // Shadow, setup age, event gap and prescaler copy; age saturates so
    // long taps fit
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ctl_reg   <= CTL_RESET;
            age_reg   <= 7'h00;
            gap_reg   <= 7'h00;
            psc_m_reg <= PSC_RESET;
        end else begin
            if (cwr) begin
                ctl_reg <= reg_wdata[7:0];
            end
            age_reg   <= cwr ? 7'h00 : (old ? age_reg : age_reg + 7'h01);
            gap_reg   <= count_en ? 7'h00 :
                         (&gap_reg ? gap_reg : gap_reg + 7'h01);
            psc_m_reg <= psc_m_reg + 6'h01;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_ext_rise;
        old && extl && !ovr && $rose(ext_clk_pin) &&
        (ctl_reg[1:0] == EDGE_00 || ctl_reg[1]);
    endsequence

    sequence s_ext_fall;
        old && extl && !ovr && $fell(ext_clk_pin) &&
        (ctl_reg[1:0] == EDGE_01 || ctl_reg[1]);
    endsequence

    // Two sync stages and the output flop lie between pin and count
    sequence s_counted;
        ##[1:5] count_en;
    endsequence

    AST_RST_QUIET: assert property (
        $rose(nrst) |-> !count_en && !phase_override)
        else $error("count or override right after reset");
    AST_DIV1_ALL: assert property (
        old && intl && ctl_reg[5:4] == PRE_DIV1 && !ovr |-> count_en)
        else $error("undivided clock missed a count");
    AST_INT_SPACING: assert property (
        old && intl && ctl_reg[5:4] != PRE_DIV1 && count_en
        |-> gap_reg == per - 7'h01)
        else $error("internal event spacing wrong");
    AST_INT_EDGE: assert property (
        old && intl && ctl_reg[5:4] != PRE_DIV1 && !ctl_reg[1] && count_en
        |-> $past(tap) == lvl)
        else $error("internal count on the wrong edge");
    AST_OVF_EACH: assert property (
        old && ctl_reg[3:2] == SRC_OVERFLOW && !ovr
        |=> count_en == $past(other_ovf))
        else $error("overflow event not counted once");
    AST_UDF_EACH: assert property (
        old && ctl_reg[3:2] == SRC_UNDERFLOW && !ovr
        |=> count_en == $past(other_udf))
        else $error("underflow event not counted once");
    AST_OVR_BLOCK: assert property (
        phase_override |-> !count_en)
        else $error("count during phase override");
    AST_OVR_CFG: assert property (
        old |-> phase_override == ovr)
        else $error("phase override level wrong");
    AST_EXT_RISE: assert property (
        s_ext_rise |-> s_counted)
        else $error("pin rise not counted");
    AST_EXT_FALL: assert property (
        s_ext_fall |-> s_counted)
        else $error("pin fall not counted");
    AST_EXT_ONCE: assert property (
        old && extl && count_en |=> !count_en)
        else $error("pin edge gave a long pulse");
endmodule

bind tes_count_edge_select tes_count_edge_select_sva #(.CHANNEL(CHANNEL))
    i_tes_count_edge_select_sva (.ref_clk, .nrst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .ext_clk_pin, .other_ovf, .other_udf,
    .count_en, .phase_override);

/* testbench/tes_src_model.sv */
// Purpose: Far-side sources: external clock pin and other-channel events.
// Assumes: Pin changes just after a clock edge; the block resamples it.
// Notes:   The pin rests low between bursts.
module tes_src_model (
    // Clock
    input wire logic ref_clk,
    // Sources
    output logic     ext_clk_pin,
    output logic     other_ovf,
    output logic     other_udf
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle sources
    initial begin
        ext_clk_pin = 1'b0;
        other_ovf = 1'b0;
        other_udf = 1'b0;
    end

    // Pin pulses, high for len cycles and low for len+1 between them; len 2 is the fastest legal
    task automatic pin_pulses(input int n, input int len);
        repeat (n) begin
            @(posedge ref_clk);
            ext_clk_pin <= 1'b1;
            repeat (len) @(posedge ref_clk);
            ext_clk_pin <= 1'b0;
            repeat (len) @(posedge ref_clk);
        end
    endtask

    // Back-to-back events on one line, one per cycle
    task automatic events(input bit udf, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            other_ovf <= !udf;
            other_udf <= udf;
        end
        @(posedge ref_clk);
        other_ovf <= 1'b0;
        other_udf <= 1'b0;
    endtask
endmodule

/* testbench/tes_count_edge_select_tb.sv */
// Purpose: Self-checking bench for count-edge qualification.
// Assumes: Channel 1, which may use phase counting.
// Notes:   Rates are judged as count growth over a fixed span.
module tes_count_edge_select_tb
    import tes_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

`define TES_CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    n_fail++; $display("unexpected at %0t: got %h expected %h", \
    $time, got, exp); end end

    logic              ref_clk   = 1'b0;
    logic              nrst      = 1'b0;
    logic [ADDR_W-1:0] reg_addr  = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 32'h0000_0000;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic              count_en;
    logic              phase_override;
    wire logic         ext_clk_pin;
    wire logic         other_ovf;
    wire logic         other_udf;
    int                n_fail    = 0;
    int                checked   = 0;

    // Internal setups and their growth per 64 cycles
    localparam logic [7:0]  ICFG [10] = '{8'h02, 8'h10, 8'h11, 8'h12,
        8'h13, 8'h23, 8'h30, 8'h32, 8'h51, 8'h53};
    localparam logic [15:0] IEXP [10] = '{16'h0040, 16'h0010, 16'h0010,
        16'h0020, 16'h0020, 16'h0008, 16'h0001, 16'h0002, 16'h0010, 16'h0020};

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    tes_count_edge_select #(.CHANNEL(1)) i_tes_count_edge_select (.ref_clk,
        .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .ext_clk_pin, .other_ovf, .other_udf, .count_en, .phase_override);
    tes_src_model i_tes_src_model (.ref_clk, .ext_clk_pin, .other_ovf,
        .other_udf);

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Count growth between two reads len cycles apart
    task automatic growth(input int len, output logic [15:0] g);
        logic [31:0] a;
        logic [31:0] b;
        rd(OFF_STATUS, a);
        repeat (len - 2) @(posedge ref_clk);
        rd(OFF_STATUS, b);
        g = b[15:0] - a[15:0];
    endtask

    task automatic t_regs;
        logic [31:0] d;
        rd(OFF_CTRL, d);
        `TES_CHK(d, 32'h0000_0000)
        wr(OFF_CTRL, 32'hffff_ff5a);
        wr(8'h0c, 32'h0000_0000);
        rd(OFF_CTRL, d);
        `TES_CHK(d, 32'h0000_005a)
        // Read data fall back to zero in the next cycle
        @(posedge ref_clk);
        #1 `TES_CHK(reg_rdata, 32'h0000_0000)
        rd(8'h08, d);
        `TES_CHK(d, 32'h0000_0000)
    endtask

    task automatic t_internal;
        logic [15:0] g;
        for (int i = 0; i < 10; i++) begin
            wr(OFF_CTRL, {24'h000000, ICFG[i]});
            repeat (128) @(posedge ref_clk);
            growth(64, g);
            `TES_CHK(g, IEXP[i])
        end
    endtask

    // Three pin pulses per code; codes 06 and 45 get the fastest pulses, len 2
    task automatic t_external;
        logic [7:0]  c [6] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h44, 8'h45};
        logic [15:0] e [6] = '{16'h3, 16'h3, 16'h6, 16'h6, 16'h3, 16'h3};
        logic [31:0] a;
        logic [31:0] b;
        for (int i = 0; i < 6; i++) begin
            wr(OFF_CTRL, {24'h000000, c[i]});
            repeat (128) @(posedge ref_clk);
            rd(OFF_STATUS, a);
            i_tes_src_model.pin_pulses(3, (i % 3 == 2) ? 2 : 5);
            repeat (8) @(posedge ref_clk);
            rd(OFF_STATUS, b);
            `TES_CHK(b[15:0] - a[15:0], e[i])
        end
    endtask

    task automatic t_events;
        logic [31:0] a;
        logic [31:0] b;
        for (int u = 0; u < 2; u++) begin
            wr(OFF_CTRL, u ? 32'h0000_000f : 32'h0000_0008);
            repeat (128) @(posedge ref_clk);
            rd(OFF_STATUS, a);
            i_tes_src_model.events(u[0], 3 + u);
            repeat (4) @(posedge ref_clk);
            rd(OFF_STATUS, b);
            `TES_CHK(b[15:0] - a[15:0], 16'(3 + u))
        end
    endtask

    task automatic t_phase;
        logic [15:0] g;
        logic [31:0] d;
        wr(OFF_CTRL, 32'h0000_00c0);
        repeat (128) @(posedge ref_clk);
        growth(64, g);
        `TES_CHK(g, 16'h0000)
        rd(OFF_STATUS, d);
        `TES_CHK(d[STA_OVR_BIT], 1'b1)
        wr(OFF_CTRL, 32'h0000_0080);
        repeat (128) @(posedge ref_clk);
        growth(64, g);
        `TES_CHK(g, 16'h0040)
        // Status write clears, but the pulse of that cycle still counts
        wr(OFF_STATUS, 32'hffff_ffff);
        rd(OFF_STATUS, d);
        `TES_CHK(d, 32'h0000_0002)
    endtask

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (50000) @(posedge ref_clk);
        n_fail++;
        complete_run();
    end

    // Main sequence after an 8-cycle reset
    initial begin
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        t_regs();
        t_internal();
        t_external();
        t_events();
        t_phase();
        complete_run();
    end
endmodule
